//--- logic/sideband_if.sv
`timescale 1ns/10ps
interface sideband_if #(
  parameter int ADDR_W      = sideband_pkg::ADDR_W_DEFAULT,
  parameter int STREAM_W    = sideband_pkg::STREAM_W_DEFAULT,
  parameter int SUBSTREAM_W = sideband_pkg::SUBSTREAM_W_DEFAULT
) (
  input wire logic clock,
  input wire logic arst_n
);
  logic                   valid;
  logic                   ready;
  logic                   is_write;
  logic [ADDR_W-1:0]      addr;
  logic [2:0]             prot;
  logic                   secure_stream_flag;
  logic [STREAM_W-1:0]    stream_ident;
  logic                   substream_valid;
  logic [SUBSTREAM_W-1:0] substream_ident;
  logic                   already_translated_flag;

  modport requester (
    input  clock, arst_n, ready,
    output valid, is_write, addr, prot, secure_stream_flag, stream_ident,
           substream_valid, substream_ident, already_translated_flag
  );

  modport translator (
    input  clock, arst_n, valid, is_write, addr, prot, secure_stream_flag,
           stream_ident, substream_valid, substream_ident, already_translated_flag,
    output ready
  );
endinterface

//--- logic/sideband_pkg.sv
package sideband_pkg;

  // ---------------------------------------------------------------------------
  // Widths and limits
  // ---------------------------------------------------------------------------
  localparam int STREAM_W_DEFAULT    = 32;
  localparam int STREAM_W_MAX        = 32;
  localparam int SUBSTREAM_W_DEFAULT = 20;
  localparam int SUBSTREAM_W_MAX     = 20;
  localparam int ADDR_W_DEFAULT      = 32;

  // ---------------------------------------------------------------------------
  // Values after reset and defaults of absent signals
  // ---------------------------------------------------------------------------
  localparam logic RESET_FLAG        = 1'h0;
  localparam logic RESET_READY       = 1'h1;
  localparam logic [2:0] RESET_PROT  = 3'h2;
  localparam int   PROT_NONSEC_BIT   = 1;

  // ---------------------------------------------------------------------------
  // Translation scheme selected for one request
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SCHEME_NONSEC_PLAIN,
    SCHEME_NONSEC_SUB,
    SCHEME_SECURE_PLAIN,
    SCHEME_SECURE_SUB,
    SCHEME_BYPASS,
    SCHEME_ILLEGAL
  } scheme_t;

endpackage

//--- logic/sideband_requester.sv
`timescale 1ns/10ps
module sideband_requester #(
  parameter int ADDR_W        = sideband_pkg::ADDR_W_DEFAULT,
  parameter int STREAM_W      = sideband_pkg::STREAM_W_DEFAULT,
  parameter int SUBSTREAM_W   = sideband_pkg::SUBSTREAM_W_DEFAULT,
  parameter int OWN_STREAM_W  = STREAM_W,
  parameter bit HAS_SIDEBAND  = 1'b1,
  parameter bit HAS_SECURE    = 1'b1,
  parameter bit HAS_SUBSTREAM = 1'b1,
  parameter bit PCIE_MODE     = 1'b0,
  parameter logic [STREAM_W-1:0] STREAM_TIE = '0
) (
  input  wire logic                   clock,
  input  wire logic                   arst_n,
  sideband_if.requester               link,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire logic                   req_is_write,
  input  wire logic [ADDR_W-1:0]      req_addr,
  input  wire logic [2:0]             req_prot,
  input  wire logic                   req_secure,
  input  wire logic [STREAM_W-1:0]    req_stream,
  input  wire logic                   req_sub_valid,
  input  wire logic [SUBSTREAM_W-1:0] req_substream,
  input  wire logic                   req_translated
);

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  if (STREAM_W < 1 || STREAM_W > sideband_pkg::STREAM_W_MAX) begin : g_bad_sw
    $error("Stream identifier width out of range.");
  end
  if (SUBSTREAM_W < 1 || SUBSTREAM_W > sideband_pkg::SUBSTREAM_W_MAX) begin : g_bad_ssw
    $error("Substream identifier width out of range.");
  end
  if (OWN_STREAM_W < 0 || OWN_STREAM_W > STREAM_W) begin : g_bad_own
    $error("Own stream width out of range.");
  end
  if (ADDR_W < 1) begin : g_bad_aw
    $error("Address width out of range.");
  end

  // ---------------------------------------------------------------------------
  // Bits of the stream identifier that this component drives itself
  // ---------------------------------------------------------------------------
  logic [STREAM_W-1:0] own_mask;

  for (genvar i = 0; i < STREAM_W; i++) begin : g_own
    assign own_mask[i] = (i < OWN_STREAM_W);
  end

  // ---------------------------------------------------------------------------
  // Legalised flags for the next request
  // ---------------------------------------------------------------------------
  logic nxt_translated;
  logic nxt_secure;
  logic nxt_sub_valid;

  // A translated request may carry neither a secure stream nor a substream.
  always_comb begin
    nxt_translated = HAS_SIDEBAND & req_translated;
    nxt_secure     = HAS_SIDEBAND & HAS_SECURE & !PCIE_MODE
                     & req_secure & !nxt_translated;
    nxt_sub_valid  = HAS_SIDEBAND & HAS_SUBSTREAM
                     & req_sub_valid & !nxt_translated;
  end

  // ---------------------------------------------------------------------------
  // Legalised identifiers for the next request
  // ---------------------------------------------------------------------------
  logic [STREAM_W-1:0]    nxt_stream;
  logic [SUBSTREAM_W-1:0] nxt_substream;

  always_comb begin
    nxt_stream = '0;
    if (HAS_SIDEBAND) begin
      nxt_stream = (req_stream & own_mask) | (STREAM_TIE & ~own_mask);
    end
  end

  always_comb begin
    nxt_substream = '0;
    if (nxt_sub_valid) begin
      nxt_substream = req_substream;
    end
  end

  // ---------------------------------------------------------------------------
  // Protection attribute for the next request
  // ---------------------------------------------------------------------------
  logic [2:0] nxt_prot;

  // A non-secure stream must never reach the fabric marked as a secure access.
  always_comb begin
    nxt_prot = req_prot;
    if (!nxt_secure) begin
      nxt_prot[sideband_pkg::PROT_NONSEC_BIT] = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Handshake towards the user and the link
  // ---------------------------------------------------------------------------
  logic valid_ff;
  logic req_ready_ff;
  logic nxt_valid;
  logic take;

  // The slot is free exactly when no request waits on the link, so ready is a
  // register at no cost: the translator accepts at most every other edge anyway.
  always_comb begin
    if (req_ready_ff) begin
      nxt_valid = req_valid;
    end else begin
      nxt_valid = !link.ready;
    end
  end

  assign take      = req_ready_ff && req_valid;
  assign req_ready = req_ready_ff;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      valid_ff <= sideband_pkg::RESET_FLAG;
    end else begin
      valid_ff <= nxt_valid;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      req_ready_ff <= sideband_pkg::RESET_READY;
    end else begin
      req_ready_ff <= !nxt_valid;
    end
  end

  // ---------------------------------------------------------------------------
  // Address channel payload, loaded only into a free slot
  // ---------------------------------------------------------------------------
  logic                   is_write_ff;
  logic [ADDR_W-1:0]      addr_ff;
  logic [2:0]             prot_ff;
  logic                   secure_ff;
  logic [STREAM_W-1:0]    stream_ff;
  logic                   sub_valid_ff;
  logic [SUBSTREAM_W-1:0] substream_ff;
  logic                   translated_ff;

  // Nothing below moves while a request waits, so the sideband stands with the address.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      is_write_ff <= sideband_pkg::RESET_FLAG;
      addr_ff     <= '0;
      prot_ff     <= sideband_pkg::RESET_PROT;
    end else if (take) begin
      is_write_ff <= req_is_write;
      addr_ff     <= req_addr;
      prot_ff     <= nxt_prot;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      secure_ff <= sideband_pkg::RESET_FLAG;
      stream_ff <= '0;
    end else if (take) begin
      secure_ff <= nxt_secure;
      stream_ff <= nxt_stream;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sub_valid_ff <= sideband_pkg::RESET_FLAG;
      substream_ff <= '0;
    end else if (take) begin
      sub_valid_ff <= nxt_sub_valid;
      substream_ff <= nxt_substream;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      translated_ff <= sideband_pkg::RESET_FLAG;
    end else if (take) begin
      translated_ff <= nxt_translated;
    end
  end

  // ---------------------------------------------------------------------------
  // Link outputs
  // ---------------------------------------------------------------------------
  assign link.valid                   = valid_ff;
  assign link.is_write                = is_write_ff;
  assign link.addr                    = addr_ff;
  assign link.prot                    = prot_ff;
  assign link.secure_stream_flag      = secure_ff;
  assign link.stream_ident            = stream_ff;
  assign link.substream_valid         = sub_valid_ff;
  assign link.substream_ident         = substream_ff;
  assign link.already_translated_flag = translated_ff;

endmodule

//--- logic/sideband_translator.sv
`timescale 1ns/10ps
module sideband_translator #(
  parameter int STREAM_W    = sideband_pkg::STREAM_W_DEFAULT,
  parameter int SUBSTREAM_W = sideband_pkg::SUBSTREAM_W_DEFAULT,
  parameter bit HAS_SIDEBAND = 1'b1
) (
  input  wire logic                   clock,
  input  wire logic                   arst_n,
  sideband_if.translator              link,
  input  wire logic                   sink_ready,
  output logic                        ctx_valid,
  output logic                        ctx_is_write,
  output sideband_pkg::scheme_t       ctx_scheme,
  output logic [STREAM_W-1:0]         ctx_stream,
  output logic [SUBSTREAM_W-1:0]      ctx_substream
);

  if (STREAM_W < 1 || STREAM_W > sideband_pkg::STREAM_W_MAX) begin : g_bad_sw
    $error("Stream identifier width out of range.");
  end
  if (SUBSTREAM_W < 1 || SUBSTREAM_W > sideband_pkg::SUBSTREAM_W_MAX) begin : g_bad_ssw
    $error("Substream identifier width out of range.");
  end

  // ---------------------------------------------------------------------------
  // Scheme selection per request
  // ---------------------------------------------------------------------------
  sideband_pkg::scheme_t nxt_scheme;
  logic                  sec;
  logic                  ssv;
  logic                  ats;

  always_comb begin
    sec = HAS_SIDEBAND & link.secure_stream_flag;
    ssv = HAS_SIDEBAND & link.substream_valid;
    ats = HAS_SIDEBAND & link.already_translated_flag;
    if (ats && (sec || ssv)) begin
      nxt_scheme = sideband_pkg::SCHEME_ILLEGAL;
    end else if (ats) begin
      nxt_scheme = sideband_pkg::SCHEME_BYPASS;
    end else if (sec && link.prot[sideband_pkg::PROT_NONSEC_BIT]) begin
      nxt_scheme = sideband_pkg::SCHEME_ILLEGAL;
    end else if (sec) begin
      nxt_scheme = ssv ? sideband_pkg::SCHEME_SECURE_SUB
                       : sideband_pkg::SCHEME_SECURE_PLAIN;
    end else if (!link.prot[sideband_pkg::PROT_NONSEC_BIT]) begin
      nxt_scheme = sideband_pkg::SCHEME_ILLEGAL;
    end else begin
      nxt_scheme = ssv ? sideband_pkg::SCHEME_NONSEC_SUB
                       : sideband_pkg::SCHEME_NONSEC_PLAIN;
    end
  end

  // ---------------------------------------------------------------------------
  // Context register, loaded on every handshake
  // ---------------------------------------------------------------------------
  logic ready_ff;
  assign link.ready = ready_ff;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ready_ff <= sideband_pkg::RESET_FLAG;
    end else begin
      ready_ff <= sink_ready && !(link.valid && ready_ff);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctx_valid <= sideband_pkg::RESET_FLAG;
    end else begin
      ctx_valid <= link.valid && ready_ff;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctx_is_write  <= sideband_pkg::RESET_FLAG;
      ctx_scheme    <= sideband_pkg::SCHEME_NONSEC_PLAIN;
      ctx_stream    <= '0;
      ctx_substream <= '0;
    end else if (link.valid && ready_ff) begin
      ctx_is_write  <= link.is_write;
      ctx_scheme    <= nxt_scheme;
      ctx_stream    <= HAS_SIDEBAND ? link.stream_ident : '0;
      ctx_substream <= ssv ? link.substream_ident : '0;
    end
  end

endmodule

//--- verification/sideband_sva.sv
`timescale 1ns/10ps
module sideband_sva #(
  parameter int ADDR_W      = 32,
  parameter int STREAM_W    = 32,
  parameter int SUBSTREAM_W = 20
) (
  input wire logic                   clock,
  input wire logic                   arst_n,
  input wire logic                   valid,
  input wire logic                   ready,
  input wire logic                   is_write,
  input wire logic [ADDR_W-1:0]      addr,
  input wire logic [2:0]             prot,
  input wire logic                   secure_stream_flag,
  input wire logic [STREAM_W-1:0]    stream_ident,
  input wire logic                   substream_valid,
  input wire logic [SUBSTREAM_W-1:0] substream_ident,
  input wire logic                   already_translated_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  AST_SUBID_ZERO: assert property (valid && !substream_valid |-> substream_ident == '0)
    else $error("substream id not zero without valid");
  AST_XLAT_NONSEC: assert property (valid && already_translated_flag |-> !secure_stream_flag)
    else $error("translated request marked secure");
  AST_XLAT_NOSUB: assert property (valid && already_translated_flag |-> !substream_valid)
    else $error("translated request carries substream");
  AST_PROT_NONSEC: assert property (valid && !secure_stream_flag |-> prot[1])
    else $error("non-secure stream without prot bit 1");
  AST_VALID_HOLD: assert property (valid && !ready |=> valid)
    else $error("request withdrawn before handshake");
  AST_PAYLOAD_HOLD: assert property (valid && !ready |=> $stable({is_write, addr, prot,
      secure_stream_flag, stream_ident, substream_valid, substream_ident,
      already_translated_flag}))
    else $error("payload changed before handshake");
  AST_RESET_DEFAULT: assert property ($rose(arst_n) |-> !valid && !secure_stream_flag
      && !substream_valid && !already_translated_flag && stream_ident == '0)
    else $error("sideband not at defaults after reset");
  AST_READY_DROP: assert property (valid && ready |=> !ready ##1 (!valid || ready)[*1]
      or !ready)
    else $error("translator accepted on two adjacent cycles");
endmodule

//--- verification/test_untranslated_txn_stream_sideband.sv
`timescale 1ns/10ps
`define CHK(n, g, x) begin num_checks++; if ((g) !== (x)) begin n_fail++; \
  $display("ERROR %s expected %0h seen %0h", n, x, g); end end
module test_untranslated_txn_stream_sideband;
  typedef struct {logic w; sideband_pkg::scheme_t s; logic [31:0] st; logic [19:0] ss;} exp_t;
  logic        clock = 0, arst_n = 0, sink_ready = 0, req_valid = 0, req_is_write = 0;
  logic        req_secure = 0, req_sub_valid = 0, req_translated = 0, req_ready;
  logic [31:0] req_addr = '0, req_stream = '0;
  logic [19:0] req_substream = '0;
  logic [2:0]  req_prot = '0;
  logic        ctx_valid, ctx_is_write;
  logic [31:0] ctx_stream;
  logic [19:0] ctx_substream;
  sideband_pkg::scheme_t ctx_scheme;
  logic        req_ready_p, ctx_valid_p, ctx_is_write_p;
  logic [31:0] ctx_stream_p;
  logic [19:0] ctx_substream_p;
  sideband_pkg::scheme_t ctx_scheme_p;
  exp_t        q[$], qp[$];
  exp_t        e, ep;
  localparam logic [31:0] PCIE_TIE = 32'h5A5A0000;
  int          n_fail = 0, num_checks = 0, cycles = 0;

  always #12.5 clock = ~clock;

  sideband_if sideband_if_i (.clock(clock), .arst_n(arst_n));
  sideband_requester sideband_requester_i (.clock(clock), .arst_n(arst_n),
    .link(sideband_if_i), .req_valid(req_valid), .req_ready(req_ready),
    .req_is_write(req_is_write), .req_addr(req_addr), .req_prot(req_prot),
    .req_secure(req_secure), .req_stream(req_stream), .req_sub_valid(req_sub_valid),
    .req_substream(req_substream), .req_translated(req_translated));
  sideband_translator sideband_translator_i (.clock(clock), .arst_n(arst_n),
    .link(sideband_if_i), .sink_ready(sink_ready), .ctx_valid(ctx_valid),
    .ctx_is_write(ctx_is_write), .ctx_scheme(ctx_scheme), .ctx_stream(ctx_stream),
    .ctx_substream(ctx_substream));
  sideband_sva sideband_sva_i (.clock(clock), .arst_n(arst_n), .valid(sideband_if_i.valid),
    .ready(sideband_if_i.ready), .is_write(sideband_if_i.is_write),
    .addr(sideband_if_i.addr), .prot(sideband_if_i.prot),
    .secure_stream_flag(sideband_if_i.secure_stream_flag),
    .stream_ident(sideband_if_i.stream_ident),
    .substream_valid(sideband_if_i.substream_valid),
    .substream_ident(sideband_if_i.substream_ident),
    .already_translated_flag(sideband_if_i.already_translated_flag));

  // Second pair: a root-complex port that drives only the low 16 identifier bits.
  sideband_if sideband_if_pcie_i (.clock(clock), .arst_n(arst_n));
  sideband_requester #(.OWN_STREAM_W(16), .PCIE_MODE(1'b1), .STREAM_TIE(PCIE_TIE))
    sideband_requester_pcie_i (.clock(clock), .arst_n(arst_n),
    .link(sideband_if_pcie_i), .req_valid(req_valid), .req_ready(req_ready_p),
    .req_is_write(req_is_write), .req_addr(req_addr), .req_prot(req_prot),
    .req_secure(req_secure), .req_stream(req_stream), .req_sub_valid(req_sub_valid),
    .req_substream(req_substream), .req_translated(req_translated));
  sideband_translator sideband_translator_pcie_i (.clock(clock), .arst_n(arst_n),
    .link(sideband_if_pcie_i), .sink_ready(sink_ready), .ctx_valid(ctx_valid_p),
    .ctx_is_write(ctx_is_write_p), .ctx_scheme(ctx_scheme_p), .ctx_stream(ctx_stream_p),
    .ctx_substream(ctx_substream_p));

  task automatic end_of_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Expected context of the request taken at this edge.
  // ---------------------------------------------------------------------------
  function automatic exp_t predict(input bit pcie);
    exp_t x;
    logic sec, sv;
    sec  = req_secure && !req_translated && !pcie;
    sv   = req_sub_valid && !req_translated;
    x.w  = req_is_write;
    x.st = pcie ? {PCIE_TIE[31:16], req_stream[15:0]} : req_stream;
    x.ss = sv ? req_substream : '0;
    if (sec && req_prot[1]) x.s = sideband_pkg::SCHEME_ILLEGAL;
    else if (req_translated) x.s = sideband_pkg::SCHEME_BYPASS;
    else if (sec) x.s = sv ? sideband_pkg::SCHEME_SECURE_SUB : sideband_pkg::SCHEME_SECURE_PLAIN;
    else x.s = sv ? sideband_pkg::SCHEME_NONSEC_SUB : sideband_pkg::SCHEME_NONSEC_PLAIN;
    return x;
  endfunction

  always @(negedge clock) sink_ready <= ($urandom % 4) != 0;

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      $display("ERROR timeout expected done seen hang");
      end_of_test();
    end
  end

  // Compares each context against the oldest note.
  always @(posedge clock) begin
    if (arst_n && ctx_valid === 1'b1) begin
      if (q.size() == 0) begin
        n_fail++;
        $display("ERROR ctx_valid expected 0 seen 1");
      end else begin
        e = q.pop_front();
        `CHK("scheme", ctx_scheme, e.s)
        `CHK("stream", ctx_stream, e.st)
        `CHK("substream", ctx_substream, e.ss)
        `CHK("is_write", ctx_is_write, e.w)
      end
    end
  end

  always @(posedge clock) begin
    if (arst_n && ctx_valid_p === 1'b1) begin
      if (qp.size() == 0) begin
        n_fail++;
        $display("ERROR ctx_valid_p expected 0 seen 1");
      end else begin
        ep = qp.pop_front();
        `CHK("pcie scheme", ctx_scheme_p, ep.s)
        `CHK("pcie stream", ctx_stream_p, ep.st)
        `CHK("pcie substream", ctx_substream_p, ep.ss)
        `CHK("pcie is_write", ctx_is_write_p, ep.w)
      end
    end
  end

  // Back-to-back requests; the first sixteen walk every flag combination.
  initial begin
    void'($urandom(72522));
    repeat (12) @(negedge clock);
    arst_n = 1;
    for (int i = 0; i < 60; i++) begin
      @(negedge clock);
      req_valid      = 1;
      req_is_write   = 1'($urandom);
      req_addr       = $urandom;
      req_stream     = (i % 5 == 0) ? '0 : $urandom;
      req_substream  = (i % 7 == 0) ? '0 : 20'($urandom);
      req_secure     = (i < 16) ? i[0] : 1'($urandom);
      req_sub_valid  = (i < 16) ? i[1] : 1'($urandom);
      req_translated = (i < 16) ? i[2] : 1'($urandom);
      req_prot       = 3'($urandom);
      req_prot[1]    = (i < 16) ? i[3] : 1'($urandom);
      while (!req_ready) @(negedge clock);
      @(posedge clock);
      `CHK("req_ready_p", req_ready_p, 1'b1)
      q.push_back(predict(1'b0));
      qp.push_back(predict(1'b1));
    end
    @(negedge clock);
    req_valid = 0;
    for (int k = 0; k < 50 && (q.size() > 0 || qp.size() > 0); k++) @(posedge clock);
    `CHK("pending", q.size(), 0)
    `CHK("pcie pending", qp.size(), 0)
    end_of_test();
  end
endmodule
